// ==== reset_seq_pkg.sv ====
// constants for the device reset sequencer
// assumes a 40 MHz system clock; times are converted to cycle counts here
package reset_seq_pkg;

    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned POR_DELAY_US  = 250;
    localparam int unsigned HW_DELAY_US   = 250;
    localparam int unsigned SW_DELAY_NS   = 100;
    localparam int unsigned HW_PULSE_NS   = 20;

    // least times round up to whole cycles, never below one
    localparam int unsigned POR_DELAY_CYC = (POR_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int unsigned HW_DELAY_CYC  = (HW_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int unsigned SW_DELAY_RAW  = (SW_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SW_DELAY_CYC  = (SW_DELAY_RAW < 1) ? 1 : SW_DELAY_RAW;
    localparam int unsigned HW_PULSE_RAW  = (HW_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned HW_PULSE_CYC  = (HW_PULSE_RAW < 1) ? 1 : HW_PULSE_RAW;

    localparam int unsigned CNT_W         = 14;
    localparam int unsigned ADDR_W        = 7;
    localparam int unsigned DATA_W        = 8;

    localparam logic [ADDR_W-1:0] ADDR_IF_CFG0   = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_IF_CFG1   = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_PWR_DOWN  = 7'h02;

    localparam int unsigned       SOFT_RESET_BIT = 7;
    localparam logic [DATA_W-1:0] IF_CFG0_RST    = 8'h00;
    localparam logic [DATA_W-1:0] IF_CFG1_RST    = 8'h00;
    // all-ones: every function block powered down
    localparam logic [DATA_W-1:0] PWR_DOWN_RST   = 8'hff;

    typedef enum logic [1:0] {
        ST_NOT_READY,
        ST_READY
    } seq_state_t;

endpackage

// ==== device_reset_sequencing.sv ====
// device reset sequencer: power-on, pin and software reset with ready delay
// assumes the host drives I_RESET_PIN_N asynchronously and register accesses
// arrive as one-cycle strobes on I_CLK_SYS
//
// Function
// RL1: power-on reset restores all register defaults
// RL2: host waits 250 us after power-on
// RL3: default mode is power-down, register 0x02
// RL4: host should pulse hardware reset after power-on
// RL5: reset pin low 20 ns starts reset
// RL6: hardware reset restores defaults, 250 us wait
// RL7: writing soft reset bit starts software reset
// RL8: soft reset spares 0x00, 0x01; 100 ns wait
// RL9: host resets device after supply drop
// RL10: below 2.7 V host must reset device
// RL11: accesses ignored until reset delay expires
`timescale 1ns/1ps

module device_reset_sequencing
    import reset_seq_pkg::*;
#(
    parameter int unsigned POR_CYC = POR_DELAY_CYC,
    parameter int unsigned HW_CYC  = HW_DELAY_CYC
)
(
    input  wire logic                             I_CLK_SYS,
    input  wire logic                             I_RESETN,
    input  wire logic                             I_RESET_PIN_N,
    input  wire logic                             I_WR,
    input  wire logic                             I_RD,
    input  wire logic [reset_seq_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic [reset_seq_pkg::DATA_W-1:0] I_WDATA,
    output logic      [reset_seq_pkg::DATA_W-1:0] O_RDATA,
    output logic                                  O_RVALID,
    output logic                                  O_READY,
    output logic      [reset_seq_pkg::DATA_W-1:0] O_PWR_DOWN
);
    import reset_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser and low-pulse qualification

    logic              pin_s1_q;
    logic              pin_s2_q;
    logic [CNT_W-1:0]  low_cnt_q;
    logic [CNT_W-1:0]  low_cnt_d;
    logic              hw_rst;

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end
        else
        begin
            pin_s1_q <= I_RESET_PIN_N;
            pin_s2_q <= pin_s1_q;
        end
    end

    // RL5: low-time qualifier
    always_comb
    begin
        low_cnt_d = low_cnt_q;
        hw_rst    = 1'b0;
        if (pin_s2_q)
        begin
            low_cnt_d = '0;
        end
        else if (low_cnt_q < CNT_W'(HW_PULSE_CYC))
        begin
            low_cnt_d = low_cnt_q + CNT_W'(1);
        end
        if (!pin_s2_q && (low_cnt_q + CNT_W'(1) >= CNT_W'(HW_PULSE_CYC)))
        begin
            hw_rst = 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            low_cnt_q <= '0;
        end
        else
        begin
            low_cnt_q <= low_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and ready sequencing

    seq_state_t        state_q;
    seq_state_t        state_d;
    logic [CNT_W-1:0]  wait_q;
    logic [CNT_W-1:0]  wait_d;
    logic [DATA_W-1:0] cfg0_q;
    logic [DATA_W-1:0] cfg0_d;
    logic [DATA_W-1:0] cfg1_q;
    logic [DATA_W-1:0] cfg1_d;
    logic [DATA_W-1:0] pwr_q;
    logic [DATA_W-1:0] pwr_d;
    logic [DATA_W-1:0] rdata_d;
    logic              rvalid_d;
    logic              soft_rst;

    function automatic logic [DATA_W-1:0] read_mux(
        input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] c0,
        input logic [DATA_W-1:0] c1,
        input logic [DATA_W-1:0] pd
    );
        logic [DATA_W-1:0] v;
        v = '0;
        case (addr)
            ADDR_IF_CFG0:  v = c0;
            ADDR_IF_CFG1:  v = c1;
            ADDR_PWR_DOWN: v = pd;
            default:       v = '0;
        endcase
        return v;
    endfunction

    always_comb
    begin
        state_d  = state_q;
        wait_d   = wait_q;
        cfg0_d   = cfg0_q;
        cfg1_d   = cfg1_q;
        pwr_d    = pwr_q;
        rdata_d  = '0;
        rvalid_d = 1'b0;
        soft_rst = 1'b0;
        case (state_q)
            ST_NOT_READY:
            begin
                // RL11: accesses ignored, count down
                if (wait_q <= CNT_W'(1))
                begin
                    state_d = ST_READY;
                    wait_d  = '0;
                end
                else
                begin
                    wait_d = wait_q - CNT_W'(1);
                end
            end
            ST_READY:
            begin
                if (I_RD)
                begin
                    rdata_d  = read_mux(I_ADDR, cfg0_q, cfg1_q, pwr_q);
                    rvalid_d = 1'b1;
                end
                if (I_WR)
                begin
                    case (I_ADDR)
                        ADDR_IF_CFG0:
                        begin
                            // RL7: soft reset bit self-clears
                            cfg0_d = I_WDATA;
                            cfg0_d[SOFT_RESET_BIT] = 1'b0;
                            soft_rst = I_WDATA[SOFT_RESET_BIT];
                        end
                        ADDR_IF_CFG1:  cfg1_d = I_WDATA;
                        ADDR_PWR_DOWN: pwr_d  = I_WDATA;
                        default:       cfg1_d = cfg1_q;
                    endcase
                end
                if (soft_rst)
                begin
                    // RL8: spares config regs, short wait
                    pwr_d   = PWR_DOWN_RST;
                    state_d = ST_NOT_READY;
                    wait_d  = CNT_W'(SW_DELAY_CYC);
                end
            end
            default:
            begin
                state_d = ST_NOT_READY;
                wait_d  = CNT_W'(POR_CYC);
            end
        endcase
        // RL6: pin reset restores everything, long wait
        if (hw_rst)
        begin
            cfg0_d   = IF_CFG0_RST;
            cfg1_d   = IF_CFG1_RST;
            pwr_d    = PWR_DOWN_RST;
            state_d  = ST_NOT_READY;
            wait_d   = CNT_W'(HW_CYC);
            rdata_d  = '0;
            rvalid_d = 1'b0;
        end
    end

    // RL1: power-on defaults
    // RL3: power-down mode out of reset
    // RL2: power-on wait loaded
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            state_q    <= ST_NOT_READY;
            wait_q     <= CNT_W'(POR_CYC);
            cfg0_q     <= IF_CFG0_RST;
            cfg1_q     <= IF_CFG1_RST;
            pwr_q      <= PWR_DOWN_RST;
            O_RDATA    <= '0;
            O_RVALID   <= 1'b0;
            O_READY    <= 1'b0;
            O_PWR_DOWN <= PWR_DOWN_RST;
        end
        else
        begin
            state_q    <= state_d;
            wait_q     <= wait_d;
            cfg0_q     <= cfg0_d;
            cfg1_q     <= cfg1_d;
            pwr_q      <= pwr_d;
            O_RDATA    <= rdata_d;
            O_RVALID   <= rvalid_d;
            O_READY    <= (state_d == ST_READY);
            O_PWR_DOWN <= pwr_d;
        end
    end

endmodule

// ==== device_reset_sequencing_checker.sv ====
// checker: ready timing and defaults at the sequencer ports
// assumes one clock domain; bound to every sequencer
`timescale 1ns/1ps
module device_reset_sequencing_checker
    import reset_seq_pkg::*;
#(
    parameter int unsigned POR_CYC = 20,
    parameter int unsigned HW_CYC  = 20
)
(
    input wire logic              I_CLK_SYS,
    input wire logic              I_RESETN,
    input wire logic              I_RESET_PIN_N,
    input wire logic              I_WR,
    input wire logic              I_RD,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [DATA_W-1:0] I_WDATA,
    input wire logic              O_READY,
    input wire logic              O_RVALID,
    input wire logic [DATA_W-1:0] O_PWR_DOWN
);
    logic [15:0] c_q, c_d, pc_q, pc_d;
    logic       sw_go;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);
    assign sw_go = O_READY && I_WR && I_ADDR == ADDR_IF_CFG0 && I_WDATA[SOFT_RESET_BIT];
    // edges since power-on; edges since the pin was last low, idle saturated
    always_comb
    begin
        c_d  = (c_q == 16'hffff) ? c_q : c_q + 16'h0001;
        pc_d = !I_RESET_PIN_N ? 16'h0000 : (pc_q == 16'hffff) ? pc_q : pc_q + 16'h0001;
    end
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            c_q  <= 16'h0000;
            pc_q <= 16'hffff;
        end
        else
        begin
            c_q  <= c_d;
            pc_q <= pc_d;
        end
    end
    ////////////////////////////////////////////////////////////////////
    property p_por; c_q <= POR_CYC |-> O_READY == (c_q == POR_CYC); endproperty
    property p_por_pd; c_q < POR_CYC |-> O_PWR_DOWN == PWR_DOWN_RST; endproperty
    property p_hw_low;
        !I_RESET_PIN_N [*4] |=> !O_READY && O_PWR_DOWN == PWR_DOWN_RST;
    endproperty
    // two synchroniser edges pass before the wait count starts
    property p_hw_wait; pc_q != 16'h0000 && pc_q < HW_CYC + 2 |-> !O_READY; endproperty
    property p_hw_up; pc_q == HW_CYC + 2 |-> O_READY; endproperty
    property p_soft;
        sw_go |=> (O_PWR_DOWN == PWR_DOWN_RST && !O_READY) [*4] ##1 O_READY;
    endproperty
    property p_rd_drop; I_RD && !O_READY |=> !O_RVALID; endproperty
    property p_wr;
        O_READY && I_WR && I_ADDR == ADDR_PWR_DOWN |=> O_PWR_DOWN == $past(I_WDATA);
    endproperty
    a_por: assert property (p_por) else $error("ready after power-on");
    a_por_pd: assert property (p_por_pd) else $error("power-down default");
    a_hw_low: assert property (p_hw_low) else $error("pin reset missed");
    a_hw_wait: assert property (p_hw_wait) else $error("ready too early");
    a_hw_up: assert property (p_hw_up) else $error("ready too late");
    a_soft: assert property (p_soft) else $error("soft reset timing");
    a_rd_drop: assert property (p_rd_drop) else $error("read not dropped");
    a_wr: assert property (p_wr) else $error("power-down write lost");
    c_soft: cover property (sw_go);
    c_pin: cover property (!I_RESET_PIN_N [*4]);
    c_rd: cover property (O_RVALID);
endmodule
bind device_reset_sequencing device_reset_sequencing_checker #(.POR_CYC(POR_CYC),
    .HW_CYC(HW_CYC)) device_reset_sequencing_checker_inst (.I_CLK_SYS, .I_RESETN,
    .I_RESET_PIN_N, .I_WR, .I_RD, .I_ADDR, .I_WDATA, .O_READY, .O_RVALID, .O_PWR_DOWN);

// ==== host_model.sv ====
// host controller model: reset pin and one-cycle strobes
// assumes tasks are called just after a rising clock edge
`timescale 1ns/1ps
module host_model
    import reset_seq_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rvalid,
    input  wire logic [DATA_W-1:0] i_rdata,
    output logic                   o_pin_n,
    output logic                   o_wr,
    output logic                   o_rd,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [DATA_W-1:0]      o_wdata
);
    initial
    begin
        o_pin_n = 1'b1;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = 7'h00;
        o_wdata = 8'h00;
    end
    task automatic pin_reset(input int n);
        o_pin_n = 1'b0;
        repeat (n) @(posedge i_clk);
        #1 o_pin_n = 1'b1;
    endtask
    // one strobe; idle address and data flip
    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
                          output logic v, output logic [7:0] q);
        @(posedge i_clk);
        #1 o_wr = w;
        o_rd    = !w;
        o_addr  = a;
        o_wdata = d;
        @(posedge i_clk);
        #1 o_wr = 1'b0;
        o_rd    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
        v       = i_rvalid;
        q       = i_rdata;
    endtask
endmodule

// ==== device_reset_sequencing_bench.sv ====
// bench: power-on, soft and pin reset of the sequencer
// assumes the host model drives all inputs but clock and power-on reset
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module device_reset_sequencing_bench;
    import reset_seq_pkg::*;
    localparam int unsigned CYC = 20;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       pin_n, wr, rd, rvalid, ready, v;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, pd, q;
    int         err_count = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    int         n;
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    device_reset_sequencing #(.POR_CYC(CYC), .HW_CYC(CYC)) device_reset_sequencing_inst (
        .I_CLK_SYS(clk), .I_RESETN(resetn), .I_RESET_PIN_N(pin_n), .I_WR(wr), .I_RD(rd),
        .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid),
        .O_READY(ready), .O_PWR_DOWN(pd));
    host_model host_model_inst (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata),
        .o_pin_n(pin_n), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    task automatic report_and_stop();
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_ready();
        n = 0;
        while (ready !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        host_model_inst.access(1'b0, a, 8'h00, v, q);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", e, q)
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_por();
        host_model_inst.access(1'b0, ADDR_PWR_DOWN, 8'h00, v, q);
        `CHK("early rvalid", 1'b0, v)
        wait_ready();
        `CHK("por cycles", CYC - 2, n)
        rd_chk(ADDR_IF_CFG0, IF_CFG0_RST);
        rd_chk(ADDR_PWR_DOWN, PWR_DOWN_RST);
    endtask
    task automatic t_soft();
        host_model_inst.access(1'b1, ADDR_PWR_DOWN, 8'h5a, v, q);
        `CHK("pwr_down", 8'h5a, pd)
        host_model_inst.access(1'b1, ADDR_IF_CFG1, 8'h3c, v, q);
        host_model_inst.access(1'b1, ADDR_IF_CFG0, 8'h91, v, q);
        `CHK("ready", 1'b0, ready)
        `CHK("pwr_down", PWR_DOWN_RST, pd)
        wait_ready();
        `CHK("soft cycles", SW_DELAY_CYC, n)
        rd_chk(ADDR_IF_CFG0, 8'h11);
        rd_chk(ADDR_IF_CFG1, 8'h3c);
    endtask
    task automatic t_pin();
        host_model_inst.access(1'b1, ADDR_PWR_DOWN, 8'ha5, v, q);
        `CHK("pwr_down", 8'ha5, pd)
        host_model_inst.pin_reset(4);
        `CHK("ready", 1'b0, ready)
        `CHK("pwr_down", PWR_DOWN_RST, pd)
        wait_ready();
        `CHK("pin wait", CYC + 2, n)
        rd_chk(ADDR_IF_CFG1, IF_CFG1_RST);
        rd_chk(ADDR_IF_CFG0, IF_CFG0_RST);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        #1 resetn = 1'b1;
        t_por();
        t_soft();
        t_pin();
        report_and_stop();
    end
endmodule
